// file: hw/mgr_regs.sv
// magnetometer data and control register bank, top level
`timescale 1ns/10ps
module mgr_regs (
   input wire logic clk,
   input wire logic sys_rst,
   input wire mgr_pkg::mgr_req_t req,
   input wire mgr_pkg::mgr_meas_t meas,
   input wire logic latch_en,
   output logic [7:0] rdata,
   output logic rvalid,
   output logic [1:0] op_mode,
   output logic [2:0] output_rate,
   output logic [1:0] advanced_selftest_ctrl,
   output logic selftest_ctrl,
   output logic three_wire_select,
   output logic power_on,
   output logic soft_reset_pulse,
   output logic por_pulse,
   output logic irq_pin
);
   typedef struct packed {
      logic [7:0] rdata;
      logic rvalid;
      logic [7:0] mode;
      logic wire3;
      logic [1:0] srst_bits;
      logic srst_pulse;
      logic por;
      logic irq;
      mgr_pkg::mgr_meas_t snap;
   } mgr_top_t;
   mgr_top_t s_q, s_d;

   logic suspended, srst_busy, srst_done, por_p, irq_lvl;
   logic pwr_wr, status_read;
   logic [7:0] rd_mux;

   // -----------------------------------------------------------------
   // power sequencing
   // -----------------------------------------------------------------
   assign pwr_wr = req.wr && (req.addr == mgr_pkg::MGR_ADDR_PWR);

   mgr_pwr_ctrl u_pwr (
      .clk(clk),
      .sys_rst(sys_rst),
      .pwr_wr(pwr_wr),
      .pwr_wdata(req.wdata),
      .suspended(suspended),
      .srst_busy(srst_busy),
      .srst_done(srst_done),
      .por_pulse(por_p)
   );

   assign status_read = req.rd && !suspended && (req.addr == mgr_pkg::MGR_ADDR_IRQ);

   mgr_irq_out u_irq (
      .clk(clk),
      .sys_rst(sys_rst),
      .irq_cond(s_q.snap.irq_cond),
      .latch_en(latch_en),
      .status_read(status_read),
      .irq_level(irq_lvl)
   );

   // -----------------------------------------------------------------
   // read multiplexer
   // -----------------------------------------------------------------
   always_comb begin
      rd_mux = 8'h00;
      if (req.addr == mgr_pkg::MGR_ADDR_PWR) begin
         rd_mux = {s_q.srst_bits[1], 4'h0, s_q.wire3, s_q.srst_bits[0],
                   !suspended};
      end else if (!suspended) begin
         case (req.addr)
            mgr_pkg::MGR_ADDR_Y_LOW:
               rd_mux = {s_q.snap.y_field[4:0], 2'h0, s_q.snap.y_selftest_flag};
            mgr_pkg::MGR_ADDR_Y_HIGH: rd_mux = s_q.snap.y_field[12:5];
            mgr_pkg::MGR_ADDR_Z_LOW:
               rd_mux = {s_q.snap.z_field[6:0], s_q.snap.z_selftest_flag};
            mgr_pkg::MGR_ADDR_Z_HIGH: rd_mux = s_q.snap.z_field[14:7];
            mgr_pkg::MGR_ADDR_R_LOW:
               rd_mux = {s_q.snap.sense_resistance[5:0], 1'b0,
                         s_q.snap.measurement_ready};
            mgr_pkg::MGR_ADDR_R_HIGH: rd_mux = s_q.snap.sense_resistance[13:6];
            mgr_pkg::MGR_ADDR_IRQ: rd_mux = s_q.snap.irq_cond;
            mgr_pkg::MGR_ADDR_MODE: rd_mux = s_q.mode;
            default: rd_mux = 8'h00;
         endcase
      end
   end

   // -----------------------------------------------------------------
   // register state
   // -----------------------------------------------------------------
   always_comb begin
      s_d = s_q;
      s_d.rvalid = req.rd;
      s_d.rdata = req.rd ? rd_mux : 8'h00;
      s_d.srst_pulse = srst_done;
      s_d.por = por_p;
      s_d.irq = irq_lvl;
      // data registers follow the measurement side, never host writes
      s_d.snap = meas;
      if (pwr_wr) begin
         s_d.wire3 = req.wdata[mgr_pkg::MGR_PWR_WIRE];
         if (!suspended) begin
            s_d.srst_bits = {req.wdata[mgr_pkg::MGR_PWR_SRST_HI],
                             req.wdata[mgr_pkg::MGR_PWR_SRST_LO]};
         end
      end
      if (req.wr && !suspended && !srst_busy && req.addr == mgr_pkg::MGR_ADDR_MODE) begin
         s_d.mode = req.wdata;
      end
      if (srst_done) begin
         s_d.mode = mgr_pkg::MGR_MODE_RESET;
         s_d.srst_bits = 2'h0;
      end
      if (suspended || por_p) begin
         s_d.mode = mgr_pkg::MGR_MODE_RESET;
         s_d.srst_bits = 2'h0;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         s_q <= '0;
         s_q.mode <= mgr_pkg::MGR_MODE_RESET;
      end else begin
         s_q <= s_d;
      end
   end

   // -----------------------------------------------------------------
   // outputs
   // -----------------------------------------------------------------
   assign rdata = s_q.rdata;
   assign rvalid = s_q.rvalid;
   assign op_mode = s_q.mode[2:1];
   assign output_rate = s_q.mode[5:3];
   assign advanced_selftest_ctrl = s_q.mode[7:6];
   assign selftest_ctrl = s_q.mode[0];
   assign three_wire_select = s_q.wire3;
   assign soft_reset_pulse = s_q.srst_pulse;
   assign por_pulse = s_q.por;
   assign irq_pin = s_q.irq;
   assign power_on = !suspended;

   a_srst_sleep: assert property (@(posedge clk) disable iff (sys_rst)
      srst_done |=> op_mode == mgr_pkg::MGR_OP_SLEEP && s_q.srst_bits == 2'h0)
      else $error("not in sleep after soft reset");
   a_y_high_map: assert property (@(posedge clk) disable iff (sys_rst)
      req.rd && !suspended && req.addr == mgr_pkg::MGR_ADDR_Y_HIGH
      |=> rdata == $past(s_q.snap.y_field[12:5]))
      else $error("y high bits wrong");
   a_r_low_zero: assert property (@(posedge clk) disable iff (sys_rst)
      $past(req.rd) && $past(req.addr) == mgr_pkg::MGR_ADDR_R_LOW |-> rdata[1] == 1'b0)
      else $error("fixed zero bit set");
   a_pwr_zeros: assert property (@(posedge clk) disable iff (sys_rst)
      $past(req.rd) && $past(req.addr) == mgr_pkg::MGR_ADDR_PWR |-> rdata[6:3] == 4'h0)
      else $error("power register fixed bits set");
   a_mode_write: assert property (@(posedge clk) disable iff (sys_rst)
      req.wr && !suspended && !srst_busy && !srst_done && !por_p
      && req.addr == mgr_pkg::MGR_ADDR_MODE |=> s_q.mode == $past(req.wdata))
      else $error("mode write lost");
endmodule // mgr_regs

// file: hw/mgr_pkg.sv
// constants and types of the magnetometer data and control register bank
package mgr_pkg;
   localparam logic [7:0] MGR_ADDR_Y_LOW = 8'h44;
   localparam logic [7:0] MGR_ADDR_Y_HIGH = 8'h45;
   localparam logic [7:0] MGR_ADDR_Z_LOW = 8'h46;
   localparam logic [7:0] MGR_ADDR_Z_HIGH = 8'h47;
   localparam logic [7:0] MGR_ADDR_R_LOW = 8'h48;
   localparam logic [7:0] MGR_ADDR_R_HIGH = 8'h49;
   localparam logic [7:0] MGR_ADDR_IRQ = 8'h4a;
   localparam logic [7:0] MGR_ADDR_PWR = 8'h4b;
   localparam logic [7:0] MGR_ADDR_MODE = 8'h4c;
   localparam logic [7:0] MGR_MODE_RESET = 8'h06;
   localparam logic [1:0] MGR_OP_NORMAL = 2'h0;
   localparam logic [1:0] MGR_OP_FORCED = 2'h1;
   localparam logic [1:0] MGR_OP_RSVD = 2'h2;
   localparam logic [1:0] MGR_OP_SLEEP = 2'h3;
   localparam int MGR_PWR_SRST_HI = 7;
   localparam int MGR_PWR_SRST_LO = 1;
   localparam int MGR_PWR_WIRE = 2;
   localparam int MGR_PWR_ON = 0;
   localparam int MGR_Y_W = 13;
   localparam int MGR_Z_W = 15;
   localparam int MGR_R_W = 14;
   // soft reset sequence length in cycles
   localparam logic [3:0] MGR_SRST_CYCLES = 4'h4;

   typedef struct packed {
      logic [MGR_Y_W-1:0] y_field;
      logic y_selftest_flag;
      logic [MGR_Z_W-1:0] z_field;
      logic z_selftest_flag;
      logic [MGR_R_W-1:0] sense_resistance;
      logic measurement_ready;
      logic [7:0] irq_cond;
   } mgr_meas_t;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } mgr_req_t;

   typedef enum logic [1:0] {MGR_SUSPEND, MGR_ACTIVE, MGR_SRST} mgr_pwr_t;
endpackage

// file: hw/mgr_pwr_ctrl.sv
// power state sequencing: suspend, active and soft reset
`timescale 1ns/10ps
module mgr_pwr_ctrl (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic pwr_wr,
   input wire logic [7:0] pwr_wdata,
   output logic suspended,
   output logic srst_busy,
   output logic srst_done,
   output logic por_pulse
);
   typedef struct packed {
      mgr_pkg::mgr_pwr_t st;
      logic [3:0] cnt;
      logic done;
      logic por;
   } mgr_pc_t;
   mgr_pc_t s_q, s_d;

   always_comb begin
      s_d = s_q;
      s_d.done = 1'b0;
      s_d.por = 1'b0;
      case (s_q.st)
         mgr_pkg::MGR_SUSPEND: begin
            // soft reset bits are ignored here
            if (pwr_wr && pwr_wdata[mgr_pkg::MGR_PWR_ON]) begin
               s_d.st = mgr_pkg::MGR_ACTIVE;
               s_d.por = 1'b1;
            end
         end
         mgr_pkg::MGR_ACTIVE: begin
            if (pwr_wr && !pwr_wdata[mgr_pkg::MGR_PWR_ON]) begin
               s_d.st = mgr_pkg::MGR_SUSPEND;
            end else if (pwr_wr && pwr_wdata[mgr_pkg::MGR_PWR_SRST_HI]
                         && pwr_wdata[mgr_pkg::MGR_PWR_SRST_LO]) begin
               s_d.st = mgr_pkg::MGR_SRST;
               s_d.cnt = mgr_pkg::MGR_SRST_CYCLES;
            end
         end
         mgr_pkg::MGR_SRST: begin
            if (s_q.cnt == 4'h1) begin
               s_d.st = mgr_pkg::MGR_ACTIVE;
               s_d.done = 1'b1;
            end
            s_d.cnt = s_q.cnt - 4'h1;
         end
         default: s_d.st = mgr_pkg::MGR_SUSPEND;
      endcase
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         s_q <= '{st: mgr_pkg::MGR_SUSPEND, cnt: 4'h0, done: 1'b0, por: 1'b0};
      end else begin
         s_q <= s_d;
      end
   end

   assign suspended = (s_q.st == mgr_pkg::MGR_SUSPEND);
   assign srst_busy = (s_q.st == mgr_pkg::MGR_SRST);
   assign srst_done = s_q.done;
   assign por_pulse = s_q.por;

   a_srst_length: assert property (@(posedge clk) disable iff (sys_rst)
      $rose(srst_busy) |-> srst_busy [*4] ##1 srst_done)
      else $error("soft reset length wrong");
   a_suspend_ignore: assert property (@(posedge clk) disable iff (sys_rst)
      suspended && pwr_wr && !pwr_wdata[mgr_pkg::MGR_PWR_ON] |=> !srst_busy)
      else $error("soft reset taken in suspend");
endmodule // mgr_pwr_ctrl

// file: hw/mgr_irq_out.sv
// interrupt pin driver with latched or level behaviour
`timescale 1ns/10ps
module mgr_irq_out (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [7:0] irq_cond,
   input wire logic latch_en,
   input wire logic status_read,
   output logic irq_level
);
   logic held_q;
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         held_q <= 1'b0;
      end else if (!latch_en) begin
         held_q <= 1'b0;
      end else if (|irq_cond) begin
         held_q <= 1'b1;
      end else if (status_read) begin
         held_q <= 1'b0;
      end
   end
   assign irq_level = latch_en ? (held_q | (|irq_cond)) : (|irq_cond);

   a_latch_hold: assert property (@(posedge clk) disable iff (sys_rst)
      latch_en && held_q && !status_read && $stable(latch_en) |=> held_q)
      else $error("latched interrupt dropped");
endmodule // mgr_irq_out

// file: verification/mgr_host_model.sv
// host side of the register port: one-cycle write and read strobes
`timescale 1ns/10ps
module mgr_host_model (
   input wire logic clk,
   input wire logic [7:0] rdata,
   input wire logic rvalid,
   output mgr_pkg::mgr_req_t req
);
   initial req = '0;
   // ---------------------------------------------------------------
   // access tasks
   // ---------------------------------------------------------------
   // idle address and data are inverted so stale values never pass for live ones
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge clk);
      req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
      @(posedge clk);
   endtask
   // answer stands for the one cycle after the strobe edge; taken at the next edge
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h5a};
      @(posedge clk);
      req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'ha5};
      @(posedge clk);
      d = (rvalid === 1'b1) ? rdata : 8'hxx;
   endtask
endmodule // mgr_host_model

// file: verification/test_mgr_regs.sv
// self-checking bench of the magnetometer register bank
`timescale 1ns/10ps
module test_mgr_regs;
   typedef struct packed {logic w; logic [7:0] a; logic [7:0] d; logic [7:0] e;} mgr_row_t;
   logic clk, sys_rst, latch_en, rvalid, three_wire_select, power_on, soft_reset_pulse;
   logic por_pulse, irq_pin, selftest_ctrl;
   logic [7:0] rdata, got, por_n, srst_n;
   logic [1:0] op_mode, advanced_selftest_ctrl, op;
   logic [2:0] output_rate;
   mgr_pkg::mgr_meas_t meas;
   mgr_pkg::mgr_req_t req;
   mgr_row_t rows [10];
   int err_total, n_tests;
   mgr_host_model host (.clk(clk), .rdata(rdata), .rvalid(rvalid), .req(req));
   mgr_regs uut (.clk(clk), .sys_rst(sys_rst), .req(req), .meas(meas), .latch_en(latch_en),
      .rdata(rdata), .rvalid(rvalid), .op_mode(op_mode), .output_rate(output_rate),
      .advanced_selftest_ctrl(advanced_selftest_ctrl), .selftest_ctrl(selftest_ctrl),
      .three_wire_select(three_wire_select), .power_on(power_on),
      .soft_reset_pulse(soft_reset_pulse), .por_pulse(por_pulse), .irq_pin(irq_pin));
   // ---------------------------------------------------------------
   // clock, pulse counters, watchdog
   // ---------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk) begin
      if (sys_rst === 1'b1) begin
         por_n <= 8'h00;
         srst_n <= 8'h00;
      end else begin
         if (por_pulse === 1'b1) por_n <= por_n + 8'h01;
         if (soft_reset_pulse === 1'b1) srst_n <= srst_n + 8'h01;
      end
   end
   initial begin
      #100000;
      err_total++;
      tally_and_finish;
   end
   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      n_tests++;
      if (g !== e) begin
         err_total++;
         $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task automatic rchk(input logic [7:0] a, input logic [7:0] e);
      host.rd(a, got);
      chk(got, e);
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic tally_and_finish;
      $display("comparisons %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial begin
      err_total = 0;
      n_tests = 0;
      sys_rst = 1'b1;
      latch_en = 1'b1;
      meas = '{13'h1abc, 1'b1, 15'h5a3c, 1'b0, 14'h2dcb, 1'b1, 8'ha5};
      rows = '{'{1'b0, 8'h45, 8'h00, 8'hd5},
         '{1'b0, 8'h44, 8'h00, 8'he1},
         '{1'b0, 8'h46, 8'h00, 8'h78},
         '{1'b0, 8'h47, 8'h00, 8'hb4},
         '{1'b0, 8'h48, 8'h00, 8'h2d},
         '{1'b0, 8'h49, 8'h00, 8'hb7},
         '{1'b1, 8'h4a, 8'hff, 8'ha5},
         '{1'b1, 8'h45, 8'h00, 8'hd5},
         '{1'b1, 8'h4b, 8'h7d, 8'h05},
         '{1'b1, 8'h4c, 8'h9b, 8'h9b}};
      cyc(12);
      sys_rst <= 1'b0;
      @(posedge clk);
      chk({op_mode, output_rate, power_on, three_wire_select, irq_pin}, 8'hc0);
      rchk(8'h45, 8'h00);
      host.wr(8'h4b, 8'h04);
      rchk(8'h4b, 8'h04);
      host.wr(8'h4b, 8'h86);
      cyc(10);
      chk({srst_n[6:0], power_on}, 8'h00);
      host.wr(8'h4b, 8'h01);
      cyc(3);
      chk({por_n[6:0], power_on}, 8'h03);
      for (int i = 0; i < 10; i++) begin
         if (rows[i].w) host.wr(rows[i].a, rows[i].d);
         rchk(rows[i].a, rows[i].e);
      end
      for (int i = 0; i < 8; i++) begin
         op = (i[1:0] == 2'h2) ? 2'h3 : i[1:0];
         host.wr(8'h4c, {i[1:0], i[2:0], op, i[0]});
         cyc(1);
         chk({advanced_selftest_ctrl, output_rate, op_mode, selftest_ctrl},
            {i[1:0], i[2:0], op, i[0]});
      end
      host.wr(8'h4c, 8'h9b);
      host.wr(8'h4b, 8'h85);
      host.wr(8'h4b, 8'h03);
      cyc(10);
      chk(srst_n, 8'h00);
      rchk(8'h4c, 8'h9b);
      host.wr(8'h4b, 8'h87);
      cyc(10);
      chk({srst_n[5:0], op_mode}, 8'h07);
      rchk(8'h4c, 8'h06);
      rchk(8'h4b, 8'h05);
      meas.irq_cond <= 8'h00;
      cyc(3);
      chk({7'h00, irq_pin}, 8'h01);
      rchk(8'h4a, 8'h00);
      cyc(2);
      chk({7'h00, irq_pin}, 8'h00);
      latch_en <= 1'b0;
      meas.irq_cond <= 8'h40;
      cyc(3);
      chk({7'h00, irq_pin}, 8'h01);
      meas.irq_cond <= 8'h00;
      cyc(3);
      chk({7'h00, irq_pin}, 8'h00);
      tally_and_finish;
   end
endmodule // test_mgr_regs
